// [hw/stcmd_defines.svh]
`ifndef STCMD_DEFINES_SVH
`define STCMD_DEFINES_SVH

// Command opcodes on the command port
`define STCMD_OP_NOP       4'h0
`define STCMD_OP_STB_QUERY 4'h1
`define STCMD_OP_TRG       4'h2
`define STCMD_OP_TST_QUERY 4'h3
`define STCMD_OP_WAI       4'h4
`define STCMD_OP_ABORT     4'h5
`define STCMD_OP_INIT      4'h6
`define STCMD_OP_CAL_STEP  4'h7
`define STCMD_OP_SEQ       4'h8

// Calibration step numbers accepted as overlapped
`define STCMD_CAL_STEP_MIN 4'h1
`define STCMD_CAL_STEP_MAX 4'h8

// Answer values and channel
`define STCMD_TST_ANSWER   8'h00
`define STCMD_CHAN_ONE     4'h1

// Arm control source encodings
`define STCMD_SRC_IMM      2'h0
`define STCMD_SRC_BUS      2'h1

`endif

// [hw/stcmd_pkg.sv]
package stcmd_pkg;

    // One command from the remote host
    typedef struct packed {
        logic [3:0] op;
        logic [3:0] arg;
    } stcmd_cmd_t;

    // One answer to a query
    typedef struct packed {
        logic [7:0] value;
    } stcmd_ans_t;

    // Trigger model states
    typedef enum logic [1:0] {
        TM_IDLE,
        TM_ARM_WAIT,
        TM_RUN
    } stcmd_tm_state_t;

    // Interpreter states
    typedef enum logic [1:0] {
        CI_READY,
        CI_WAIT_OVL
    } stcmd_ci_state_t;

endpackage : stcmd_pkg

// [hw/stcmd_decode.sv]
`timescale 1ns/1ps
`default_nettype none
`include "stcmd_defines.svh"

module stcmd_decode
    import stcmd_pkg::*;
(
    // Command in
    input  wire logic       cmd_valid_i,
    input  wire stcmd_cmd_t cmd_i,
    // Decoded classes
    output logic            is_ovl_o,
    output logic            is_query_o,
    output logic            is_wai_o
);

    // Overlapped: trigger, initiate, cal steps one to eight
    function automatic logic ovl_class(input stcmd_cmd_t c);
        ovl_class = (c.op == `STCMD_OP_TRG) || (c.op == `STCMD_OP_INIT) ||
                    ((c.op == `STCMD_OP_CAL_STEP) &&
                     (c.arg >= `STCMD_CAL_STEP_MIN) &&
                     (c.arg <= `STCMD_CAL_STEP_MAX));
    endfunction : ovl_class

    // Pure combinational classification
    always_comb begin
        is_ovl_o   = cmd_valid_i && ovl_class(cmd_i);
        is_query_o = cmd_valid_i && ((cmd_i.op == `STCMD_OP_STB_QUERY) ||
                                     (cmd_i.op == `STCMD_OP_TST_QUERY));
        is_wai_o   = cmd_valid_i && (cmd_i.op == `STCMD_OP_WAI);
    end

endmodule : stcmd_decode
`default_nettype wire

// [hw/stcmd_trig_model.sv]
`timescale 1ns/1ps
`default_nettype none
`include "stcmd_defines.svh"

module stcmd_trig_model
    import stcmd_pkg::*;
(
    // Clock and reset
    input  wire logic            core_clk_i,
    input  wire logic            nrst_i,
    // Control
    input  wire logic            init_i,
    input  wire logic            bus_trig_i,
    input  wire logic            abort_i,
    input  wire logic            cont_init_i,
    input  wire logic [1:0]      arm_src_i,
    input  wire logic            meas_done_i,
    // Status
    output stcmd_tm_state_t      state_o,
    output logic                 meas_start_o,
    output logic                 busy_o
);

    ////////////////////////////////////////////////////////////////////////
    stcmd_tm_state_t state_reg, state_next;
    logic            start_reg, start_next;

    // Abort has top priority; a bus trigger only arms with BUS source
    always_comb begin
        state_next = state_reg;
        start_next = 1'b0;
        if (abort_i) begin
            state_next = cont_init_i ? TM_ARM_WAIT : TM_IDLE;
        end else begin
            case (state_reg)
                TM_IDLE: begin
                    if (init_i || cont_init_i) begin
                        state_next = TM_ARM_WAIT;
                    end
                end
                TM_ARM_WAIT: begin
                    if (arm_src_i == `STCMD_SRC_IMM ||
                        (bus_trig_i && arm_src_i == `STCMD_SRC_BUS)) begin
                        state_next = TM_RUN;
                        start_next = 1'b1;
                    end
                end
                TM_RUN: begin
                    if (meas_done_i) begin
                        state_next = cont_init_i ? TM_ARM_WAIT : TM_IDLE;
                    end
                end
                default: state_next = TM_IDLE;
            endcase
        end
    end

    // Registers only
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg <= TM_IDLE;
            start_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            start_reg <= start_next;
        end
    end

    assign state_o      = state_reg;
    assign meas_start_o = start_reg;
    assign busy_o       = (state_reg != TM_IDLE) && !cont_init_i;

    ////////////////////////////////////////////////////////////////////////
    // Checks on abort handling and trigger gating
    property p_abort_idle;
        @(posedge core_clk_i) disable iff (!nrst_i)
        abort_i && !cont_init_i |=> state_reg == TM_IDLE;
    endproperty
    a_abort_idle: assert property (p_abort_idle)
        else $error("abort without continuous did not go idle");

    property p_abort_top;
        @(posedge core_clk_i) disable iff (!nrst_i)
        abort_i && cont_init_i |=> state_reg == TM_ARM_WAIT;
    endproperty
    a_abort_top: assert property (p_abort_top)
        else $error("abort with continuous did not restart");

    property p_bus_gate;
        @(posedge core_clk_i) disable iff (!nrst_i)
        state_reg == TM_ARM_WAIT && arm_src_i != `STCMD_SRC_IMM &&
        !(bus_trig_i && arm_src_i == `STCMD_SRC_BUS)
        |=> state_reg != TM_RUN;
    endproperty
    a_bus_gate: assert property (p_bus_gate)
        else $error("trigger model ran without bus trigger");

endmodule : stcmd_trig_model
`default_nettype wire

// [hw/stcmd_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "stcmd_defines.svh"

module stcmd_top
    import stcmd_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        nrst_i,
    // Command port
    input  wire logic        cmd_valid_i,
    input  wire stcmd_cmd_t  cmd_i,
    output logic             cmd_ready_o,
    // Answer port
    output logic             ans_valid_o,
    output stcmd_ans_t       ans_o,
    // Group execute trigger from the bus
    input  wire logic        get_i,
    // Status byte kept elsewhere
    input  wire logic [7:0]  status_byte_i,
    // Trigger model settings
    input  wire logic        cont_init_i,
    input  wire logic [1:0]  arm_src_i,
    // Overlapped operation completion
    input  wire logic        meas_done_i,
    input  wire logic        cal_done_i,
    // Sequential command execution
    output logic             seq_start_o,
    input  wire logic        seq_done_i,
    // Trigger model view
    output stcmd_tm_state_t  tm_state_o,
    output logic             meas_start_o,
    output logic             cal_start_o,
    output logic [3:0]       cal_step_o,
    output logic             abort_err_o
);

    ////////////////////////////////////////////////////////////////////////
    // Decode
    logic is_ovl;
    logic is_query;
    logic is_wai;

    stcmd_decode u_decode (
        .cmd_valid_i (cmd_valid_i),
        .cmd_i       (cmd_i),
        .is_ovl_o    (is_ovl),
        .is_query_o  (is_query),
        .is_wai_o    (is_wai)
    );

    ////////////////////////////////////////////////////////////////////////
    // Interpreter state
    stcmd_ci_state_t ci_reg,      ci_next;
    logic            seqb_reg,    seqb_next;
    logic            calb_reg,    calb_next;
    logic            ans_v_reg,   ans_v_next;
    logic [7:0]      ans_reg,     ans_next;
    logic            seq_st_reg,  seq_st_next;
    logic            cal_st_reg,  cal_st_next;
    logic [3:0]      step_reg,    step_next;
    logic            aerr_reg,    aerr_next;

    logic            take;
    logic            tm_busy;
    logic            ovl_busy;
    logic            trig_pulse;
    logic            init_pulse;
    logic            abort_pulse;

    // Overlapped work still in progress: calibration, or trigger model not idle while not continuous
    assign ovl_busy = tm_busy || calb_reg || cal_st_reg;

    // Sequential command blocks intake; wait blocks while overlap runs
    always_comb begin
        cmd_ready_o = 1'b0;
        case (ci_reg)
            CI_READY:    cmd_ready_o = !seqb_reg && !seq_st_reg;
            CI_WAIT_OVL: cmd_ready_o = 1'b0;
            default:     cmd_ready_o = 1'b0;
        endcase
    end

    assign take = cmd_valid_i && cmd_ready_o;

    // Bus trigger and remote trigger command are one and the same event
    assign trig_pulse  = get_i || (take && cmd_i.op == `STCMD_OP_TRG);
    assign init_pulse  = take && cmd_i.op == `STCMD_OP_INIT;
    assign abort_pulse = take && cmd_i.op == `STCMD_OP_ABORT;

    // Next-state logic of the interpreter
    always_comb begin
        ci_next     = ci_reg;
        seqb_next   = seqb_reg;
        calb_next   = calb_reg;
        ans_v_next  = 1'b0;
        ans_next    = ans_reg;
        seq_st_next = 1'b0;
        cal_st_next = 1'b0;
        step_next   = step_reg;
        aerr_next   = aerr_reg;
        // Completion of work started earlier
        if (seqb_reg && seq_done_i) begin
            seqb_next = 1'b0;
        end
        if (calb_reg && cal_done_i) begin
            calb_next = 1'b0;
        end
        if (cal_st_reg) begin
            calb_next = 1'b1;
        end
        case (ci_reg)
            CI_READY: begin
                if (take) begin
                    case (cmd_i.op)
                        `STCMD_OP_STB_QUERY: begin
                            // A read copy only; nothing is written back
                            ans_next   = status_byte_i;
                            ans_v_next = 1'b1;
                        end
                        `STCMD_OP_TST_QUERY: begin
                            ans_next   = `STCMD_TST_ANSWER;
                            ans_v_next = 1'b1;
                        end
                        `STCMD_OP_WAI: begin
                            if (ovl_busy) begin
                                ci_next = CI_WAIT_OVL;
                            end
                        end
                        `STCMD_OP_CAL_STEP: begin
                            if (is_ovl) begin
                                cal_st_next = 1'b1;
                                step_next   = cmd_i.arg;
                            end else begin
                                seq_st_next = 1'b1;
                                seqb_next   = 1'b1;
                            end
                        end
                        `STCMD_OP_ABORT: begin
                            // Single channel part: flag a wrong suffix
                            aerr_next = (cmd_i.arg != `STCMD_CHAN_ONE);
                        end
                        `STCMD_OP_SEQ: begin
                            seq_st_next = 1'b1;
                            seqb_next   = 1'b1;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            CI_WAIT_OVL: begin
                if (!ovl_busy) begin
                    ci_next = CI_READY;
                end
            end
            default: ci_next = CI_READY;
        endcase
    end

    // Registers only
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ci_reg     <= CI_READY;
            seqb_reg   <= 1'b0;
            calb_reg   <= 1'b0;
            ans_v_reg  <= 1'b0;
            ans_reg    <= 8'h00;
            seq_st_reg <= 1'b0;
            cal_st_reg <= 1'b0;
            step_reg   <= 4'h0;
            aerr_reg   <= 1'b0;
        end else begin
            ci_reg     <= ci_next;
            seqb_reg   <= seqb_next;
            calb_reg   <= calb_next;
            ans_v_reg  <= ans_v_next;
            ans_reg    <= ans_next;
            seq_st_reg <= seq_st_next;
            cal_st_reg <= cal_st_next;
            step_reg   <= step_next;
            aerr_reg   <= aerr_next;
        end
    end

    assign ans_valid_o = ans_v_reg;
    assign ans_o.value = ans_reg;
    assign seq_start_o = seq_st_reg;
    assign cal_start_o = cal_st_reg;
    assign cal_step_o  = step_reg;
    assign abort_err_o = aerr_reg;

    ////////////////////////////////////////////////////////////////////////
    // Trigger model
    stcmd_trig_model u_tm (
        .core_clk_i   (core_clk_i),
        .nrst_i       (nrst_i),
        .init_i       (init_pulse),
        .bus_trig_i   (trig_pulse),
        .abort_i      (abort_pulse),
        .cont_init_i  (cont_init_i),
        .arm_src_i    (arm_src_i),
        .meas_done_i  (meas_done_i),
        .state_o      (tm_state_o),
        .meas_start_o (meas_start_o),
        .busy_o       (tm_busy)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_stb_answer;
        @(posedge core_clk_i) disable iff (!nrst_i)
        take && cmd_i.op == `STCMD_OP_STB_QUERY
        |=> ans_valid_o && ans_o.value == $past(status_byte_i);
    endproperty
    a_stb_answer: assert property (p_stb_answer)
        else $error("status answer differs from status byte");

    property p_tst_zero;
        @(posedge core_clk_i) disable iff (!nrst_i)
        take && cmd_i.op == `STCMD_OP_TST_QUERY
        |=> ans_valid_o && ans_o.value == 8'h00;
    endproperty
    a_tst_zero: assert property (p_tst_zero)
        else $error("self-test answer not zero");

    property p_wai_hold;
        @(posedge core_clk_i) disable iff (!nrst_i)
        ci_reg == CI_WAIT_OVL && ovl_busy |-> !cmd_ready_o;
    endproperty
    a_wai_hold: assert property (p_wai_hold)
        else $error("command taken while overlapped work runs");

    property p_wai_enter;
        @(posedge core_clk_i) disable iff (!nrst_i)
        take && is_wai && ovl_busy |=> ci_reg == CI_WAIT_OVL;
    endproperty
    a_wai_enter: assert property (p_wai_enter)
        else $error("wait did not hold off");

    // A wait must not outlive the overlapped work it waits for
    property p_wai_release;
        @(posedge core_clk_i) disable iff (!nrst_i)
        ci_reg == CI_WAIT_OVL && !ovl_busy |=> cmd_ready_o;
    endproperty
    a_wai_release: assert property (p_wai_release)
        else $error("wait still held after overlapped work ended");

    property p_seq_hold;
        @(posedge core_clk_i) disable iff (!nrst_i)
        take && cmd_i.op == `STCMD_OP_SEQ
        |=> (!cmd_ready_o ##1 !cmd_ready_o) or seq_done_i;
    endproperty
    a_seq_hold: assert property (p_seq_hold)
        else $error("next command taken before sequential finished");

    // Intake stays shut for as long as the sequential engine works
    property p_seq_busy;
        @(posedge core_clk_i) disable iff (!nrst_i)
        seqb_reg && !seq_done_i |=> !cmd_ready_o;
    endproperty
    a_seq_busy: assert property (p_seq_busy)
        else $error("command intake open while sequential runs");

    property p_ovl_free;
        @(posedge core_clk_i) disable iff (!nrst_i)
        take && is_ovl && !is_query |=> cmd_ready_o;
    endproperty
    a_ovl_free: assert property (p_ovl_free)
        else $error("overlapped command blocked intake");

    property p_trg_get;
        @(posedge core_clk_i) disable iff (!nrst_i)
        take && cmd_i.op == `STCMD_OP_TRG && tm_state_o == TM_ARM_WAIT &&
        arm_src_i == `STCMD_SRC_BUS && !get_i |=> meas_start_o;
    endproperty
    a_trg_get: assert property (p_trg_get)
        else $error("trigger command did not act as bus trigger");

    // The bus strobe itself must start a measurement just the same
    property p_get_trig;
        @(posedge core_clk_i) disable iff (!nrst_i)
        get_i && !abort_pulse && tm_state_o == TM_ARM_WAIT &&
        arm_src_i == `STCMD_SRC_BUS |=> meas_start_o;
    endproperty
    a_get_trig: assert property (p_get_trig)
        else $error("group execute trigger did not start measurement");

    property p_abort_stop;
        @(posedge core_clk_i) disable iff (!nrst_i)
        abort_pulse |=> tm_state_o != TM_RUN;
    endproperty
    a_abort_stop: assert property (p_abort_stop)
        else $error("abort left trigger model running");

endmodule : stcmd_top
`default_nettype wire

// [tb/stcmd_far_model.sv]
`timescale 1ns/1ps
`default_nettype none

// Far-side engines: each start pulse not restarted by a later one is answered by one done pulse
module stcmd_far_model (
    // Clock
    input  wire logic       core_clk_i,
    // Starts {seq, cal, meas} and reply delay in cycles, at least 1
    input  wire logic [2:0] start_i,
    input  wire logic [7:0] dly_i,
    // Done pulses {seq, cal, meas}
    output logic      [2:0] done_o
);
    int cnt [3] = '{0, 0, 0};

    initial done_o = 3'b000;

    // Driven off the falling edge; a new start restarts the count
    always @(negedge core_clk_i) begin
        for (int k = 0; k < 3; k++) begin
            done_o[k] <= (cnt[k] == 1);
            if (cnt[k] != 0) cnt[k] <= cnt[k] - 1;
            if (start_i[k]) cnt[k] <= dly_i;
        end
    end
endmodule : stcmd_far_model

`default_nettype wire

// [tb/tb_stcmd_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "stcmd_defines.svh"

module tb_stcmd_top
    import stcmd_pkg::*;
;
    logic            clk  = 0;
    logic            rn   = 0;
    logic            vld  = 0;
    logic            get  = 0;
    logic            cont = 0;
    logic [1:0]      src  = `STCMD_SRC_BUS;
    logic [7:0]      stb  = 8'h00;
    logic [7:0]      dly  = 8'h14;
    stcmd_cmd_t      cmd  = '0;
    logic            rdy, av, ss, ms, cs, ae;
    logic [3:0]      cstep;
    logic [2:0]      done;
    stcmd_ans_t      ans;
    stcmd_tm_state_t tm;
    int              miscompares = 0;
    int              n_checks    = 0;
    int              cyc = 0;
    int              t0  = 0;
    int              t_dn [3] = '{0, 0, 0};
    // Status values with the answer each must give
    logic [15:0]     rows [5] = '{16'h9191, 16'h0000, 16'hffff,
                                  16'h0101, 16'h8080};

    ////////////////////////////////////////////////////////////////////
    stcmd_top dut_u (
        .core_clk_i(clk), .nrst_i(rn), .cmd_valid_i(vld), .cmd_i(cmd),
        .cmd_ready_o(rdy), .ans_valid_o(av), .ans_o(ans), .get_i(get),
        .status_byte_i(stb), .cont_init_i(cont), .arm_src_i(src),
        .meas_done_i(done[0]), .cal_done_i(done[1]), .seq_start_o(ss),
        .seq_done_i(done[2]), .tm_state_o(tm), .meas_start_o(ms),
        .cal_start_o(cs), .cal_step_o(cstep), .abort_err_o(ae)
    );

    stcmd_far_model far_u (
        .core_clk_i(clk), .start_i({ss, cs, ms}), .dly_i(dly),
        .done_o(done)
    );

    ////////////////////////////////////////////////////////////////////
    // Clock, 100 MHz
    initial forever #5 clk = ~clk;

    // Cycle count and the cycle of the last done per engine
    always @(posedge clk) begin
        cyc <= cyc + 1;
        for (int k = 0; k < 3; k++) if (done[k]) t_dn[k] <= cyc;
    end

    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task end_sim;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim

    // Offer at a falling edge, hold until taken, return after the take
    // One idle cycle first, so valid never drops and rises in one step
    task send(input logic [3:0] op, input logic [3:0] arg);
        int i;
        @(negedge clk);
        vld = 1'b1;
        cmd = {op, arg};
        for (i = 0; i < 60 && rdy !== 1'b1; i++) @(negedge clk);
        if (i == 60) begin
            miscompares++;
            end_sim();
        end else begin
            @(negedge clk);
            vld = 1'b0;
        end
    endtask : send

    task query(input logic [3:0] op, input logic [7:0] e);
        send(op, 4'h0);
        chk("ans_valid", 8'h01, {7'h00, av});
        chk("ans", e, ans.value);
    endtask : query

    task chk_tm(input stcmd_tm_state_t e);
        chk("tm_state", {6'h00, e}, {6'h00, tm});
    endtask : chk_tm

    ////////////////////////////////////////////////////////////////////
    // Main sequence; expectations follow from the rules alone
    initial begin
        repeat (4) @(negedge clk);
        chk_tm(TM_IDLE);
        chk("ready", 8'h01, {7'h00, rdy});
        rn = 1'b1;
        foreach (rows[r]) begin
            stb = rows[r][15:8];
            query(`STCMD_OP_STB_QUERY, rows[r][7:0]);
            query(`STCMD_OP_STB_QUERY, rows[r][7:0]);
        end
        stb = 8'h00;
        query(`STCMD_OP_STB_QUERY, 8'h00);
        query(`STCMD_OP_TST_QUERY, `STCMD_TST_ANSWER);
        // Source that is not the bus: trigger must be ignored
        src = 2'h2;
        send(`STCMD_OP_INIT, 4'h0);
        send(`STCMD_OP_TRG, 4'h0);
        chk_tm(TM_ARM_WAIT);
        send(`STCMD_OP_ABORT, `STCMD_CHAN_ONE);
        chk_tm(TM_IDLE);
        chk("abort_err", 8'h00, {7'h00, ae});
        // Bus source: trigger command, then wait for the measurement
        src = `STCMD_SRC_BUS;
        send(`STCMD_OP_INIT, 4'h0);
        t0 = cyc;
        send(`STCMD_OP_TRG, 4'h0);
        chk_tm(TM_RUN);
        chk("meas_start", 8'h01, {7'h00, ms});
        send(`STCMD_OP_WAI, 4'h0);
        chk("ready", 8'h00, {7'h00, rdy});
        query(`STCMD_OP_STB_QUERY, stb);
        chk("meas_order", 8'h01, {7'h00, t_dn[0] > t0});
        // Group execute trigger, then abort in mid-run
        send(`STCMD_OP_INIT, 4'h0);
        get = 1'b1;
        @(negedge clk);
        get = 1'b0;
        chk_tm(TM_RUN);
        send(`STCMD_OP_ABORT, `STCMD_CHAN_ONE);
        chk_tm(TM_IDLE);
        // Continuous initiation: abort restarts at the top
        cont = 1'b1;
        repeat (3) @(negedge clk);
        send(`STCMD_OP_TRG, 4'h0);
        send(`STCMD_OP_ABORT, `STCMD_CHAN_ONE);
        chk_tm(TM_ARM_WAIT);
        cont = 1'b0;
        send(`STCMD_OP_ABORT, `STCMD_CHAN_ONE);
        chk_tm(TM_IDLE);
        // Immediate source arms at once; a wrong channel is flagged
        src = `STCMD_SRC_IMM;
        send(`STCMD_OP_INIT, 4'h0);
        @(negedge clk);
        chk_tm(TM_RUN);
        chk("meas_start", 8'h01, {7'h00, ms});
        send(`STCMD_OP_ABORT, 4'h2);
        chk_tm(TM_IDLE);
        chk("abort_err", 8'h01, {7'h00, ae});
        src = `STCMD_SRC_BUS;
        // Every overlapped calibration step held off by a wait
        dly = 8'h0c;
        for (int k = 1; k <= 8; k++) begin
            t0 = cyc;
            send(`STCMD_OP_CAL_STEP, 4'(k));
            chk("cal_step", 8'(k), {4'h0, cstep});
            send(`STCMD_OP_WAI, 4'h0);
            chk("ready", 8'h00, {7'h00, rdy});
            query(`STCMD_OP_STB_QUERY, stb);
            chk("cal_order", 8'h01, {7'h00, t_dn[1] > t0});
        end
        // Nothing outstanding: a wait does not stall
        send(`STCMD_OP_WAI, 4'h0);
        chk("ready", 8'h01, {7'h00, rdy});
        // Sequential: step nine and the generic command
        for (int k = 0; k < 2; k++) begin
            t0 = cyc;
            if (k == 0) send(`STCMD_OP_CAL_STEP, 4'h9);
            else send(`STCMD_OP_SEQ, 4'h0);
            chk("seq_start", 8'h01, {7'h00, ss});
            chk("ready", 8'h00, {7'h00, rdy});
            query(`STCMD_OP_STB_QUERY, stb);
            chk("seq_order", 8'h01, {7'h00, t_dn[2] > t0});
        end
        // Reset in mid-run cuts off a sequential operation
        send(`STCMD_OP_SEQ, 4'h0);
        rn = 1'b0;
        @(negedge clk);
        chk("ready", 8'h01, {7'h00, rdy});
        chk("seq_start", 8'h00, {7'h00, ss});
        chk("ans_valid", 8'h00, {7'h00, av});
        chk("abort_err", 8'h00, {7'h00, ae});
        chk_tm(TM_IDLE);
        rn = 1'b1;
        query(`STCMD_OP_TST_QUERY, `STCMD_TST_ANSWER);
        end_sim();
    end
endmodule : tb_stcmd_top

`default_nettype wire
